// >>> logic/adsc_defs.svh
`ifndef ADSC_DEFS_SVH
`define ADSC_DEFS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADSC_ADDR_CON1    8'hb4
`define ADSC_ADDR_SEQ     8'hb5
`define ADSC_ADDR_EXTRA   8'hb6
`define ADSC_ADDR_RES_LO  8'hba
`define ADSC_ADDR_RES_HI  8'hbb

// ----------------------------------------------------------------
// reset values and field codes
// ----------------------------------------------------------------
`define ADSC_SRC_PIN      2'h0
`define ADSC_SRC_FREE     2'h1
`define ADSC_SRC_TIMER    2'h2
`define ADSC_SRC_SOFT     2'h3
`define ADSC_RST_SRC      2'h3
`define ADSC_RST_RSV      2'h3
`define ADSC_RST_REF      2'h0
`define ADSC_RST_DEC      2'h1
`define ADSC_RST_CH       4'h0
`define ADSC_RNG_NORMAL   2'h0
`define ADSC_RNG_SINGLE   2'h1
`define ADSC_ST_BIT       6
`define ADSC_SRC_FIELD    5:4

// ----------------------------------------------------------------
// channel map
// ----------------------------------------------------------------
`define ADSC_CH_DIFF0     4'h8
`define ADSC_CH_SEQ_MAX   4'hc
`define ADSC_NUM_PINS     8

// ----------------------------------------------------------------
// timing: 32 MHz system clock divided by 8 gives the 4 MHz enable
// ----------------------------------------------------------------
`define ADSC_DIV_LAST     3'h7
`define ADSC_SETTLE_LAST  10'h00f
`define ADSC_DEC64_LAST   10'h03f
`define ADSC_DEC128_LAST  10'h07f
`define ADSC_DEC256_LAST  10'h0ff
`define ADSC_DEC512_LAST  10'h1ff

// result masks per resolution (14-bit left-justified value)
`define ADSC_MASK8        14'h3fc0
`define ADSC_MASK10       14'h3ff0
`define ADSC_MASK12       14'h3ffc
`define ADSC_MASK13       14'h3ffe

`endif

// >>> logic/adsc_pkg.sv
package adsc_pkg;

  // ----------------------------------------------------------------
  // conversion controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ADSC_IDLE   = 4'b0001,
    ADSC_SETTLE = 4'b0010,
    ADSC_FILTER = 4'b0100,
    ADSC_FINISH = 4'b1000
  } adsc_state_t;

  // one conversion setup: reference, decimation, channel
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [1:0] dec_sel;
    logic [3:0] chan;
  } adsc_cfg_t;

  // channel search answer
  typedef struct packed {
    logic       found;
    logic [3:0] chan;
  } adsc_pick_t;

endpackage : adsc_pkg

// >>> logic/adsc_top.sv
`timescale 1ns/1ns
`include "adsc_defs.svh"
// Operation
// - done flag sets at conversion end, clears after both result bytes read.
// - a new completion before reading keeps the done flag high.
// - start bit write begins sequence only with software source and idle.
// - start bit reads one while sequence runs, hardware clears it at end; only sequences launched by the start bit set it.
// - start source: pin edge, free running, timer compare, start bit.
// - sequence channel field gives the last channel of a sequence.
// - writing extra config launches one extra conversion with its fields.
// - extra config fields decode exactly as sequence config fields.
// - results are two's complement, 14-bit span 8191 to -8192.
// - reading sequence channel field returns channel of held result.
// - converter runs on 4 MHz enable, system clock divided by 8.
// - conversion is 16 settle periods plus decimation rate periods.
// - interrupt on extra conversion end only, never for sequence.
// - each sequence conversion pulses DMA; extra conversion does not.
// - separate DMA trigger for each of channels 0 to 7.
// - any-channel DMA trigger on every sequence result.
// - result left-justified: high byte 13:6, low 7:2, low 1:0 zero.
// - random control: normal, single step self-reverting, reserved, stop.
// - sequence 0..end below 8, from 8 for 8..12, else single.
// - channel codes map; disabled-input channels are skipped in a sequence, but an extra conversion converts its channel regardless.
// - decimation codes 64,128,256,512; reset code 01.
// - reference codes internal, top pin, supply, top differential pair.
module adsc_top
  import adsc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // start events and pin setup
  input  wire logic        external_trigger_pin,
  input  wire logic        timer1_ch0_compare,
  input  wire logic [7:0]  analog_input_enable,
  // modulator abstraction
  input  wire logic [13:0] mod_sample,
  output logic             mod_tick,
  output logic      [3:0]  mod_channel,
  output logic      [1:0]  mod_reference,
  // random generator hook
  input  wire logic        rng_single_done,
  output logic      [1:0]  random_generator_control,
  // interrupt and dma
  output logic             irq,
  output logic      [7:0]  per_channel_dma_trigger,
  output logic             any_channel_dma_trigger
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adsc_state_t state_q;
  adsc_cfg_t   seq_cfg_q;
  adsc_cfg_t   xtra_cfg_q;
  adsc_cfg_t   cur_cfg_q;
  adsc_pick_t  first_pick;
  adsc_pick_t  next_pick;
  logic [2:0]  div_q;
  logic        tick_q;
  logic [9:0]  cnt_q;
  logic [9:0]  dec_last;
  logic        seq_on_q;
  logic        cur_extra_q;
  logic        xtra_pend_q;
  logic        st_q;
  logic [1:0]  src_q;
  logic [1:0]  rng_q;
  logic [1:0]  rsv_q;
  logic        eoc_q;
  logic        lo_read_q;
  logic        hi_read_q;
  logic [13:0] result_q;
  logic [3:0]  res_ch_q;
  logic        pin_q;
  logic        idle;
  logic        seq_start;
  logic        soft_go;
  logic        xtra_start;
  logic        done;
  logic        wr_con1;
  logic        wr_seq;
  logic        wr_xtra;

  assign idle    = (state_q == ADSC_IDLE);
  assign wr_con1 = sfr_wr && (sfr_addr == `ADSC_ADDR_CON1);
  assign wr_seq  = sfr_wr && (sfr_addr == `ADSC_ADDR_SEQ);
  assign wr_xtra = sfr_wr && (sfr_addr == `ADSC_ADDR_EXTRA);
  assign done    = (state_q == ADSC_FINISH);

  // ----------------------------------------------------------------
  // channel helpers
  // ----------------------------------------------------------------
  // a channel is usable when its input pins are analog enabled
  function automatic logic ch_ok(input logic [3:0] ch,
                                 input logic [7:0] en);
    logic ok;
    ok = 1'b1;
    if (ch < `ADSC_CH_DIFF0) begin
      ok = en[ch[2:0]];
    end else if (ch < `ADSC_CH_SEQ_MAX) begin
      ok = en[{ch[1:0], 1'b0}] && en[{ch[1:0], 1'b1}];
    end
    return ok;
  endfunction : ch_ok

  // lowest usable channel in [lo, hi]
  function automatic adsc_pick_t pick(input logic [3:0] lo,
                                      input logic [3:0] hi,
                                      input logic [7:0] en);
    adsc_pick_t p;
    p = '0;
    for (int i = 15; i >= 0; i--) begin
      if ((4'(i) >= lo) && (4'(i) <= hi) && ch_ok(4'(i), en)) begin
        p.found = 1'b1;
        p.chan  = 4'(i);
      end
    end
    return p;
  endfunction : pick

  // first channel of a sequence from the programmed end channel
  always_comb begin
    if (seq_cfg_q.chan > `ADSC_CH_SEQ_MAX) begin
      first_pick = '{found: 1'b1, chan: seq_cfg_q.chan};
    end else if (seq_cfg_q.chan >= `ADSC_CH_DIFF0) begin
      first_pick = pick(`ADSC_CH_DIFF0, seq_cfg_q.chan,
                        analog_input_enable);
    end else begin
      first_pick = pick(4'h0, seq_cfg_q.chan,
                        analog_input_enable);
    end
  end

  // next channel after the one just converted, up to the end channel
  always_comb begin
    next_pick = '0;
    if ((cur_cfg_q.chan < seq_cfg_q.chan) &&
        (seq_cfg_q.chan <= `ADSC_CH_SEQ_MAX)) begin
      next_pick = pick(cur_cfg_q.chan + 4'h1, seq_cfg_q.chan,
                       analog_input_enable);
    end
  end

  // ----------------------------------------------------------------
  // start decisions
  // ----------------------------------------------------------------
  // extra conversions wait for a running sequence to finish
  assign xtra_start = idle && xtra_pend_q && !seq_on_q;

  // start bit counts only if the same write keeps the bit source, so a
  // write that moves the source away cannot launch a sequence
  assign soft_go = wr_con1 && sfr_wdata[`ADSC_ST_BIT] &&
                   (sfr_wdata[`ADSC_SRC_FIELD] == `ADSC_SRC_SOFT);

  // sequence trigger by selected source; busy ignores all of them
  always_comb begin
    seq_start = 1'b0;
    unique case (src_q)
      `ADSC_SRC_PIN:   seq_start = external_trigger_pin && !pin_q;
      `ADSC_SRC_FREE:  seq_start = 1'b1;
      `ADSC_SRC_TIMER: seq_start = timer1_ch0_compare;
      `ADSC_SRC_SOFT:  seq_start = 1'b0;
    endcase
    seq_start = (seq_start || soft_go) && idle && !seq_on_q &&
                !xtra_pend_q;
  end

  // ----------------------------------------------------------------
  // 4 MHz enable from the system clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_q  <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_q + 3'h1;
      tick_q <= (div_q == `ADSC_DIV_LAST);
    end
  end

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cur_cfg_q.dec_sel)
      2'h0: dec_last = `ADSC_DEC64_LAST;
      2'h1: dec_last = `ADSC_DEC128_LAST;
      2'h2: dec_last = `ADSC_DEC256_LAST;
      2'h3: dec_last = `ADSC_DEC512_LAST;
    endcase
  end

  // settle then filter, both counted in 4 MHz periods
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= ADSC_IDLE;
      cnt_q   <= 10'h000;
    end else begin
      unique case (state_q)
        ADSC_IDLE: begin
          cnt_q <= 10'h000;
          if (xtra_start || (seq_start && first_pick.found)) begin
            state_q <= ADSC_SETTLE;
          end
        end
        ADSC_SETTLE: begin
          if (tick_q) begin
            cnt_q <= cnt_q + 10'h001;
            if (cnt_q == `ADSC_SETTLE_LAST) begin
              cnt_q   <= 10'h000;
              state_q <= ADSC_FILTER;
            end
          end
        end
        ADSC_FILTER: begin
          if (tick_q) begin
            cnt_q <= cnt_q + 10'h001;
            if (cnt_q == dec_last) begin
              state_q <= ADSC_FINISH;
            end
          end
        end
        ADSC_FINISH: begin
          cnt_q   <= 10'h000;
          state_q <= (seq_on_q && next_pick.found) ? ADSC_SETTLE
                                                   : ADSC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequence bookkeeping and active setup
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seq_on_q    <= 1'b0;
      cur_extra_q <= 1'b0;
      cur_cfg_q   <= '{`ADSC_RST_REF, `ADSC_RST_DEC, `ADSC_RST_CH};
    end else if (xtra_start) begin
      cur_extra_q <= 1'b1;
      cur_cfg_q   <= xtra_cfg_q;
    end else if (seq_start && first_pick.found) begin
      seq_on_q    <= 1'b1;
      cur_extra_q <= 1'b0;
      cur_cfg_q   <= '{seq_cfg_q.ref_sel, seq_cfg_q.dec_sel,
                       first_pick.chan};
    end else if (done) begin
      if (seq_on_q && next_pick.found) begin
        cur_cfg_q <= '{seq_cfg_q.ref_sel, seq_cfg_q.dec_sel,
                       next_pick.chan};
      end else begin
        seq_on_q <= 1'b0;
      end
    end
  end

  // extra request waits here; a rewrite while pending only refreshes it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      xtra_pend_q <= 1'b0;
    end else if (wr_xtra) begin
      xtra_pend_q <= 1'b1;
    end else if (xtra_start) begin
      xtra_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  // start bit: write one only counts for the software source
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= 1'b0;
    end else if (seq_start && soft_go) begin
      st_q <= first_pick.found;
    end else if (done && !(seq_on_q && next_pick.found)) begin
      st_q <= 1'b0;
    end
  end

  // source select, reserved pair and pin edge history
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      src_q <= `ADSC_RST_SRC;
      rsv_q <= `ADSC_RST_RSV;
      pin_q <= 1'b0;
    end else begin
      pin_q <= external_trigger_pin;
      if (wr_con1) begin
        src_q <= sfr_wdata[`ADSC_SRC_FIELD];
        rsv_q <= sfr_wdata[1:0];
      end
    end
  end

  // random control: single step falls back to normal when done
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rng_q <= `ADSC_RNG_NORMAL;
    end else if (wr_con1) begin
      rng_q <= sfr_wdata[3:2];
    end else if ((rng_q == `ADSC_RNG_SINGLE) && rng_single_done) begin
      rng_q <= `ADSC_RNG_NORMAL;
    end
  end

  // sequence and extra setup; mid-conversion changes are not guarded
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seq_cfg_q  <= '{`ADSC_RST_REF, `ADSC_RST_DEC, `ADSC_RST_CH};
      xtra_cfg_q <= '{`ADSC_RST_REF, `ADSC_RST_DEC, `ADSC_RST_CH};
    end else begin
      if (wr_seq) begin
        seq_cfg_q <= sfr_wdata;
      end
      if (wr_xtra) begin
        xtra_cfg_q <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // result capture and done flag
  // ----------------------------------------------------------------
  // keep only the bits the chosen resolution delivers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      result_q <= 14'h0000;
      res_ch_q <= `ADSC_RST_CH;
    end else if (done) begin
      res_ch_q <= cur_cfg_q.chan;
      unique case (cur_cfg_q.dec_sel)
        2'h0: result_q <= mod_sample & `ADSC_MASK8;
        2'h1: result_q <= mod_sample & `ADSC_MASK10;
        2'h2: result_q <= mod_sample & `ADSC_MASK12;
        2'h3: result_q <= mod_sample & `ADSC_MASK13;
      endcase
    end
  end

  // flag clears after both bytes; a completion always wins the clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      eoc_q     <= 1'b0;
      lo_read_q <= 1'b0;
      hi_read_q <= 1'b0;
    end else if (done) begin
      eoc_q     <= 1'b1;
      lo_read_q <= 1'b0;
      hi_read_q <= 1'b0;
    end else if (sfr_rd) begin
      if (sfr_addr == `ADSC_ADDR_RES_LO) begin
        lo_read_q <= 1'b1;
        if (hi_read_q) begin
          eoc_q <= 1'b0;
        end
      end
      if (sfr_addr == `ADSC_ADDR_RES_HI) begin
        hi_read_q <= 1'b1;
        if (lo_read_q) begin
          eoc_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port, one cycle after the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `ADSC_ADDR_CON1:   sfr_rdata <= {eoc_q, st_q, src_q, rng_q, rsv_q};
        `ADSC_ADDR_SEQ:    sfr_rdata <= {seq_cfg_q.ref_sel,
                                         seq_cfg_q.dec_sel,
                                         res_ch_q};
        `ADSC_ADDR_EXTRA:  sfr_rdata <= xtra_cfg_q;
        `ADSC_ADDR_RES_LO: sfr_rdata <= {result_q[5:0], 2'b00};
        `ADSC_ADDR_RES_HI: sfr_rdata <= result_q[13:6];
        default:           sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // completion outputs: irq for extra, dma for sequence
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq                     <= 1'b0;
      any_channel_dma_trigger <= 1'b0;
      per_channel_dma_trigger <= 8'h00;
    end else begin
      irq                     <= done && cur_extra_q;
      any_channel_dma_trigger <= done && !cur_extra_q;
      per_channel_dma_trigger <= 8'h00;
      if (done && !cur_extra_q && (cur_cfg_q.chan < `ADSC_CH_DIFF0)) begin
        per_channel_dma_trigger[cur_cfg_q.chan[2:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered modulator and random generator controls
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mod_tick                 <= 1'b0;
      mod_channel              <= `ADSC_RST_CH;
      mod_reference            <= `ADSC_RST_REF;
      random_generator_control <= `ADSC_RNG_NORMAL;
    end else begin
      mod_tick                 <= tick_q && !idle;
      mod_channel              <= cur_cfg_q.chan;
      mod_reference            <= cur_cfg_q.ref_sel;
      random_generator_control <= rng_q;
    end
  end

endmodule : adsc_top

// >>> tb/adsc_far_model.sv
`timescale 1ns/1ns
module adsc_far_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // converter setup and events
  input  wire logic [3:0] mod_channel,
  input  wire logic [1:0] mod_reference,
  input  wire logic       irq,
  input  wire logic [7:0] per_channel_dma_trigger,
  input  wire logic       any_channel_dma_trigger,
  // sample back to the converter
  output logic     [13:0] mod_sample
);
  logic [15:0] chan_cnt [8];
  logic [15:0] any_cnt;
  logic [15:0] irq_cnt;
  logic [15:0] done_cnt;
  // sample carries channel and reference so a wrong decode shows
  assign mod_sample = {mod_channel, mod_reference, 8'h5a};
  // dma and interrupt side: count every pulse
  always @(posedge core_clk) begin
    if (!nrst) begin
      any_cnt <= 16'h0000;
      irq_cnt <= 16'h0000;
      done_cnt <= 16'h0000;
      chan_cnt <= '{default: 16'h0000};
    end else begin
      any_cnt <= any_cnt + 16'(any_channel_dma_trigger);
      irq_cnt <= irq_cnt + 16'(irq);
      done_cnt <= done_cnt + 16'(any_channel_dma_trigger) + 16'(irq);
      for (int i = 0; i < 8; i++)
        chan_cnt[i] <= chan_cnt[i] + 16'(per_channel_dma_trigger[i]);
    end
  end
endmodule : adsc_far_model

// >>> tb/adsc_props.sv
`timescale 1ns/1ns
module adsc_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_rd,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_rdata,
  // converter and events
  input wire logic       mod_tick,
  input wire logic       rng_single_done,
  input wire logic [1:0] random_generator_control,
  input wire logic       irq,
  input wire logic [7:0] per_channel_dma_trigger,
  input wire logic       any_channel_dma_trigger
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // --------------------
  // helper logic
  // --------------------
  logic [9:0] tk_q;
  logic       fin;
  assign fin = irq | any_channel_dma_trigger;
  // ticks since last completion; a tick on the end cycle starts the next
  always_ff @(posedge core_clk) begin
    if (!nrst)
      tk_q <= 10'h000;
    else if (fin)
      tk_q <= {9'h000, mod_tick};
    else
      tk_q <= tk_q + {9'h000, mod_tick};
  end
  // --------------------
  // properties
  // --------------------
  chk_tick_space: assert property (mod_tick |=> !mod_tick [*7])
    else $error("tick spacing wrong");
  chk_conv_len: assert property (
    fin |-> tk_q inside {10'd80, 10'd144, 10'd272, 10'd528})
    else $error("conversion length wrong");
  chk_irq_no_dma: assert property (
    irq |-> !any_channel_dma_trigger && per_channel_dma_trigger == 8'h00)
    else $error("dma beside interrupt");
  chk_chan_any: assert property (
    |per_channel_dma_trigger |->
      any_channel_dma_trigger && $onehot(per_channel_dma_trigger))
    else $error("channel trigger without any trigger");
  chk_irq_once: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
  chk_dma_once: assert property (fin |=> !any_channel_dma_trigger)
    else $error("dma trigger too long");
  chk_rng_back: assert property (
    rng_single_done && random_generator_control == 2'h1 && !sfr_wr
      |-> ##[1:2] random_generator_control == 2'h0)
    else $error("single step did not revert");
  chk_low_zero: assert property (
    sfr_rd && sfr_addr == 8'hba |=> sfr_rdata[1:0] == 2'h0)
    else $error("low byte spare bits set");
  cov_irq: cover property (irq);
  cov_ch2: cover property (per_channel_dma_trigger[2]);
  cov_rng: cover property (rng_single_done && random_generator_control == 2'h1);
endmodule : adsc_props

bind adsc_top adsc_props adsc_props_i (
  .core_clk(core_clk),
  .nrst(nrst),
  .sfr_addr(sfr_addr),
  .sfr_rd(sfr_rd),
  .sfr_wr(sfr_wr),
  .sfr_rdata(sfr_rdata),
  .mod_tick(mod_tick),
  .rng_single_done(rng_single_done),
  .random_generator_control(random_generator_control),
  .irq(irq),
  .per_channel_dma_trigger(per_channel_dma_trigger),
  .any_channel_dma_trigger(any_channel_dma_trigger)
);

// >>> tb/adsc_top_bench.sv
`timescale 1ns/1ns
`include "adsc_defs.svh"
module adsc_top_bench;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        external_trigger_pin = 1'b0;
  logic        timer1_ch0_compare = 1'b0;
  logic [7:0]  analog_input_enable = 8'h05;
  logic        rng_single_done = 1'b0;
  logic [7:0]  sfr_rdata;
  logic [13:0] mod_sample;
  logic        mod_tick;
  logic [3:0]  mod_channel;
  logic [1:0]  mod_reference;
  logic [1:0]  random_generator_control;
  logic        irq;
  logic [7:0]  per_channel_dma_trigger;
  logic        any_channel_dma_trigger;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [7:0]  d;
  logic [7:0]  hi;
  logic [13:0] masks [4] = '{`ADSC_MASK8, `ADSC_MASK10, `ADSC_MASK12,
                             `ADSC_MASK13};

  always #10 core_clk = ~core_clk;

  adsc_top adsc_top_i (.core_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .external_trigger_pin, .timer1_ch0_compare,
    .analog_input_enable, .mod_sample, .mod_tick, .mod_channel,
    .mod_reference, .rng_single_done, .random_generator_control, .irq,
    .per_channel_dma_trigger, .any_channel_dma_trigger);
  adsc_far_model far_i (.core_clk, .nrst, .mod_channel, .mod_reference,
    .irq, .per_channel_dma_trigger, .any_channel_dma_trigger, .mod_sample);

  // --------------------
  // access tasks
  // --------------------
  // all tasks start and end 2 ns after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #2;
    sfr_wr = 1'b0;
    // one idle edge so a following write never re-raises the strobe at once
    @(posedge core_clk);
    #2;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #2;
    sfr_rd = 1'b0;
    @(posedge core_clk);
    #2;
    v = sfr_rdata;
  endtask : rd

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string n);
    rd(a, d);
    chk(n, d, e);
  endtask : rd_chk

  // bounded wait on the completion count seen by the far side
  task automatic wait_done(input logic [15:0] n);
    int k;
    k = 0;
    while (far_i.done_cnt < n && k < 6000) begin
      @(posedge core_clk);
      #2;
      k++;
    end
    chk("completions", far_i.done_cnt, n);
  endtask : wait_done

  // high byte first so the done flag must survive a single read
  task automatic rd_res(input logic [3:0] ch, input logic [1:0] rf,
                        input logic [13:0] m);
    logic [13:0] s;
    s = {ch, rf, 8'h5a} & m;
    rd(`ADSC_ADDR_RES_HI, hi);
    rd(`ADSC_ADDR_CON1, d);
    chk("done after one byte", d[7], 1'b1);
    rd(`ADSC_ADDR_RES_LO, d);
    chk("result", {hi, d}, {s[13:6], s[5:0], 2'b00});
    rd(`ADSC_ADDR_CON1, d);
    chk("done cleared", d[7], 1'b0);
  endtask : rd_res

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // --------------------
  // tests
  // --------------------
  initial begin
    repeat (20) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    rd_chk(`ADSC_ADDR_CON1, 8'h33, "control reset");
    rd_chk(`ADSC_ADDR_SEQ, 8'h10, "sequence reset");
    rd_chk(`ADSC_ADDR_RES_LO, 8'h00, "low reset");
    rd_chk(`ADSC_ADDR_RES_HI, 8'h00, "high reset");
    rd_chk(8'hb0, 8'h00, "unmapped");
    // end channel 3 asked, channels 1 and 3 disabled
    wr(`ADSC_ADDR_SEQ, 8'h03);
    wr(`ADSC_ADDR_CON1, 8'h73);
    rd(`ADSC_ADDR_CON1, d);
    chk("start bit busy", d[6], 1'b1);
    wait_done(16'h0002);
    for (int i = 0; i < 4; i++)
      chk("channel dma", far_i.chan_cnt[i], 16'(1 - i % 2));
    chk("any dma", far_i.any_cnt, 16'h0002);
    chk("no sequence irq", far_i.irq_cnt, 16'h0000);
    rd_chk(`ADSC_ADDR_CON1, 8'hb3, "done set, start clear");
    rd_chk(`ADSC_ADDR_SEQ, 8'h02, "held channel");
    rd_res(4'h2, 2'h0, masks[0]);
    // every reference and decimation code through the extra path
    for (int i = 0; i < 4; i++) begin
      wr(`ADSC_ADDR_EXTRA, {i[1:0], i[1:0], 4'hc + 4'(i)});
      wait_done(16'(3 + i));
      chk("extra irq", far_i.irq_cnt, 16'(i + 1));
      chk("no extra dma", far_i.any_cnt, 16'h0002);
      rd(`ADSC_ADDR_SEQ, d);
      chk("extra channel", d[3:0], 4'hc + 4'(i));
      rd_res(4'hc + 4'(i), i[1:0], masks[i]);
    end
    // start bit ignored unless the source is the start bit
    wr(`ADSC_ADDR_CON1, 8'h43);
    rd_chk(`ADSC_ADDR_CON1, 8'h03, "start refused");
    repeat (700) @(posedge core_clk);
    #2;
    chk("nothing started", far_i.done_cnt, 16'h0006);
    external_trigger_pin = 1'b1;
    wait_done(16'h0008);
    external_trigger_pin = 1'b0;
    wr(`ADSC_ADDR_CON1, 8'h23);
    timer1_ch0_compare = 1'b1;
    @(posedge core_clk);
    #2;
    timer1_ch0_compare = 1'b0;
    wait_done(16'h000a);
    rd(`ADSC_ADDR_RES_HI, hi);
    wr(`ADSC_ADDR_CON1, 8'h13);
    wait_done(16'h000e);
    // high byte was read before these completions: low alone must not clear
    rd(`ADSC_ADDR_RES_LO, d);
    rd(`ADSC_ADDR_CON1, d);
    chk("done kept high", d[7], 1'b1);
    wr(`ADSC_ADDR_CON1, 8'h33);
    wait_done(16'h0010);
    repeat (700) @(posedge core_clk);
    #2;
    chk("free run stopped", far_i.done_cnt, 16'h0010);
    chk("channel 2 dma", far_i.chan_cnt[2], 16'h0006);
    // random generator control field
    wr(`ADSC_ADDR_CON1, 8'h37);
    rd(`ADSC_ADDR_CON1, d);
    chk("rng single", {d[3:2], random_generator_control}, 4'h5);
    rng_single_done = 1'b1;
    @(posedge core_clk);
    #2;
    rng_single_done = 1'b0;
    rd(`ADSC_ADDR_CON1, d);
    chk("rng revert", {d[3:2], random_generator_control}, 4'h0);
    wr(`ADSC_ADDR_CON1, 8'h3f);
    rd(`ADSC_ADDR_CON1, d);
    chk("rng stop", {d[3:2], random_generator_control}, 4'hf);
    wrap_up();
  end

  // watchdog well beyond the roughly 18000 cycles the tests need
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
endmodule : adsc_top_bench
